// [hdl/wdx_defines.svh]
// register map, field positions and reset values of the wakeup / direct-transfer flag block
`ifndef WDX_DEFINES_SVH
`define WDX_DEFINES_SVH

// byte addresses of the register words
`define WDX_ADDR_WAKE_FLAG   8'h00
`define WDX_ADDR_DX_FLAG     8'h04
`define WDX_ADDR_WAKE_SEL    8'h08
`define WDX_ADDR_MODE_CTL    8'h0c
`define WDX_ADDR_IRQ_STAT    8'h10
`define WDX_ADDR_IRQ_MASK    8'h14
`define WDX_ADDR_OP_MODE     8'h18

// field positions of the mode control word
`define WDX_MC_ALLOW         0
`define WDX_MC_STANDBY       1
`define WDX_MC_MEDIUM        2
`define WDX_MC_LOW           3
`define WDX_MC_TIMER_A_MODE_BIT3          4
`define WDX_MC_DX_IE         5
`define WDX_MC_WIDTH         6

// field positions of the sticky status word
`define WDX_ST_DX_EV         8
`define WDX_ST_WIDTH         9

// reset values
`define WDX_RST_WAKE_FLAG    8'h00
`define WDX_RST_WAKE_SEL     8'h00
`define WDX_RST_MODE_CTL     6'h00
`define WDX_RST_IRQ_STAT     9'h000
`define WDX_RST_IRQ_MASK     9'h000
`define WDX_RST_PIN_PREV     1'b1

`endif

// [hdl/wdx_pkg.sv]
// types shared by the wakeup / direct-transfer flag block
package wdx_pkg;

   // operating mode of the core clocking
   typedef enum logic [1:0] {
      WDX_MODE_HIGH = 2'b00,
      WDX_MODE_MED  = 2'b01,
      WDX_MODE_SUB  = 2'b10
   } wdx_mode_e;

   // mode control bits as software sets them
   typedef struct packed {
      logic dx_irq_en;
      logic timer_a_mode_bit3;
      logic low_speed_select;
      logic medium_speed_select;
      logic standby_select;
      logic direct_xfer_allow;
   } wdx_modectl_s;

   // outcome of a sleep instruction
   typedef struct packed {
      logic      xfer;
      wdx_mode_e target;
   } wdx_xfer_s;

endpackage

// [hdl/wdx_fall_det.sv]
// falling edge detector for the wakeup pins
`timescale 1ns/1ps
`default_nettype none
`include "wdx_defines.svh"

module wdx_fall_det #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // pins and edge pulses
   input  wire logic [WIDTH-1:0] pin_n,
   output logic      [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] prev_r;

   // idle level of a wakeup pin is high, so reset assumes high
   always_ff @(posedge clk) begin
      if (reset) begin
         prev_r <= {WIDTH{`WDX_RST_PIN_PREV}};
      end else begin
         prev_r <= pin_n;
      end
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_fall
         assign fall[g] = prev_r[g] & ~pin_n[g];
      end
   endgenerate

endmodule
`default_nettype wire

// [hdl/wdx_irq_flags.sv]
// wakeup and direct-transfer request flags with apb register slave
`timescale 1ns/1ps
`default_nettype none
`include "wdx_defines.svh"

// Function
// - sleep with transfer allowed and a real direct transfer sets direct flag.
// - writing 0 to direct flag while it reads 1 clears it.
// - software writes only clear flags; writing 1 never sets one.
// - eight wake flags; each set by falling edge on interrupt-configured pin.
// - writing 0 to one wake flag reading 1 clears it, others untouched.
// - direct-transfer interrupt enable gates the direct flag's interrupt request.
// - sleep picks medium, high or subactive target from select bits.
module wdx_irq_flags #(
   parameter int NPIN = 8
) (
   // clock and reset
   input  wire logic            clk,
   input  wire logic            reset,
   // apb slave
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [7:0]      paddr,
   input  wire logic [31:0]     pwdata,
   output logic      [31:0]     prdata,
   output logic                 pready,
   output logic                 pslverr,
   // wakeup pins and core
   input  wire logic [NPIN-1:0] wake_pin_n,
   input  wire logic            sleep_exec,
   // requests and state
   output logic                 wake_irq_req,
   output logic                 direct_xfer_irq_req,
   output logic      [1:0]      op_mode,
   output logic                 irq
);

   logic [NPIN-1:0]          wake_flag_r;
   logic [NPIN-1:0]          wake_sel_r;
   logic                     dx_flag_r;
   wdx_pkg::wdx_modectl_s    ctl_r;
   wdx_pkg::wdx_mode_e       mode_r;
   logic [`WDX_ST_WIDTH-1:0] stat_r;
   logic [`WDX_ST_WIDTH-1:0] mask_r;
   logic [`WDX_ST_WIDTH-1:0] stat_rd_r;
   logic [31:0]              prdata_r;
   logic [31:0]              rd_nxt;
   logic                     slverr_nxt;
   logic [NPIN-1:0]          pin_fall;
   logic [NPIN-1:0]          wake_set_ev;
   logic                     dx_ev;
   wdx_pkg::wdx_xfer_s       xfer;
   logic                     setup;
   logic                     wr_acc;
   logic                     rd_acc;
   logic                     mapped;
   logic [`WDX_ST_WIDTH-1:0] stat_set;

   // target mode of a sleep instruction, xfer low when no direct transfer
   function automatic wdx_pkg::wdx_xfer_s sleep_target(
      input wdx_pkg::wdx_mode_e    m,
      input wdx_pkg::wdx_modectl_s c
   );
      wdx_pkg::wdx_xfer_s r;
      r.xfer   = 1'b0;
      r.target = m;
      if (c.direct_xfer_allow) begin
         if (c.standby_select && c.timer_a_mode_bit3 && c.low_speed_select
             && m != wdx_pkg::WDX_MODE_SUB) begin
            r.xfer   = 1'b1;
            r.target = wdx_pkg::WDX_MODE_SUB;
         end else if (!c.standby_select && !c.low_speed_select) begin
            if (m == wdx_pkg::WDX_MODE_HIGH && c.medium_speed_select) begin
               r.xfer   = 1'b1;
               r.target = wdx_pkg::WDX_MODE_MED;
            end else if (m == wdx_pkg::WDX_MODE_MED && !c.medium_speed_select) begin
               r.xfer   = 1'b1;
               r.target = wdx_pkg::WDX_MODE_HIGH;
            end
         end
      end
      return r;
   endfunction

   wdx_fall_det #(
      .WIDTH (NPIN)
   ) u_fall (
      .clk   (clk),
      .reset (reset),
      .pin_n (wake_pin_n),
      .fall  (pin_fall)
   );

   assign wake_set_ev = pin_fall & wake_sel_r;
   assign xfer        = sleep_target(mode_r, ctl_r);
   assign dx_ev       = sleep_exec & xfer.xfer;

   // apb decode
   assign setup   = psel & ~penable;
   assign wr_acc  = psel & penable & pwrite;
   assign rd_acc  = psel & penable & ~pwrite;
   assign pready  = 1'b1;
   assign prdata  = prdata_r;
   assign pslverr = psel & penable & ~mapped;

   always_comb begin
      rd_nxt     = 32'h0000_0000;
      slverr_nxt = 1'b0;
      case (paddr)
         `WDX_ADDR_WAKE_FLAG: rd_nxt[NPIN-1:0] = wake_flag_r;
         `WDX_ADDR_DX_FLAG:   rd_nxt[0] = dx_flag_r;
         `WDX_ADDR_WAKE_SEL:  rd_nxt[NPIN-1:0] = wake_sel_r;
         `WDX_ADDR_MODE_CTL:  rd_nxt[`WDX_MC_WIDTH-1:0] = ctl_r;
         `WDX_ADDR_IRQ_STAT:  rd_nxt[`WDX_ST_WIDTH-1:0] = stat_r;
         `WDX_ADDR_IRQ_MASK:  rd_nxt[`WDX_ST_WIDTH-1:0] = mask_r;
         `WDX_ADDR_OP_MODE:   rd_nxt[1:0] = mode_r;
         default:             slverr_nxt = 1'b1;
      endcase
   end

   // mapped is held from setup to access because the master holds paddr
   assign mapped = ~slverr_nxt;

   // read data is captured at the setup edge
   always_ff @(posedge clk) begin
      if (reset) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata_r <= rd_nxt;
      end
   end

   // wake request flags: set beats clear
   always_ff @(posedge clk) begin
      if (reset) begin
         wake_flag_r <= `WDX_RST_WAKE_FLAG;
      end else if (wr_acc && paddr == `WDX_ADDR_WAKE_FLAG) begin
         wake_flag_r <= (wake_flag_r & pwdata[NPIN-1:0]) | wake_set_ev;
      end else begin
         wake_flag_r <= wake_flag_r | wake_set_ev;
      end
   end

   // direct transfer request flag: set beats clear
   always_ff @(posedge clk) begin
      if (reset) begin
         dx_flag_r <= 1'b0;
      end else if (wr_acc && paddr == `WDX_ADDR_DX_FLAG) begin
         dx_flag_r <= (dx_flag_r & pwdata[0]) | dx_ev;
      end else begin
         dx_flag_r <= dx_flag_r | dx_ev;
      end
   end

   // configuration registers
   always_ff @(posedge clk) begin
      if (reset) begin
         wake_sel_r <= `WDX_RST_WAKE_SEL;
         ctl_r      <= `WDX_RST_MODE_CTL;
         mask_r     <= `WDX_RST_IRQ_MASK;
      end else if (wr_acc) begin
         if (paddr == `WDX_ADDR_WAKE_SEL) begin
            wake_sel_r <= pwdata[NPIN-1:0];
         end
         if (paddr == `WDX_ADDR_MODE_CTL) begin
            ctl_r <= pwdata[`WDX_MC_WIDTH-1:0];
         end
         if (paddr == `WDX_ADDR_IRQ_MASK) begin
            mask_r <= pwdata[`WDX_ST_WIDTH-1:0];
         end
      end
   end

   // operating mode follows direct transfers
   always_ff @(posedge clk) begin
      if (reset) begin
         mode_r <= wdx_pkg::WDX_MODE_HIGH;
      end else if (dx_ev) begin
         mode_r <= xfer.target;
      end
   end

   // sticky status: a read clears only what that read returned
   assign stat_set = {dx_ev, wake_set_ev};

   always_ff @(posedge clk) begin
      if (reset) begin
         stat_rd_r <= `WDX_RST_IRQ_STAT;
      end else if (setup && !pwrite && paddr == `WDX_ADDR_IRQ_STAT) begin
         stat_rd_r <= stat_r;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         stat_r <= `WDX_RST_IRQ_STAT;
      end else if (rd_acc && paddr == `WDX_ADDR_IRQ_STAT) begin
         stat_r <= (stat_r & ~stat_rd_r) | stat_set;
      end else begin
         stat_r <= stat_r | stat_set;
      end
   end

   assign irq                 = |(stat_r & mask_r);
   assign wake_irq_req        = |wake_flag_r;
   assign direct_xfer_irq_req = dx_flag_r & ctl_r.dx_irq_en;
   assign op_mode             = mode_r;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   wake_set_a: assert property (
      (wake_set_ev != 8'h00) |=> ((wake_flag_r & $past(wake_set_ev)) == $past(wake_set_ev)))
      else $error("wake flag not set by falling edge");

   no_write_set_a: assert property (
      1'b1 |=> ((wake_flag_r & ~$past(wake_flag_r) & ~$past(wake_set_ev)) == 8'h00)
               && !(dx_flag_r && !$past(dx_flag_r) && !$past(dx_ev)))
      else $error("flag set without hardware event");

   wake_clr_a: assert property (
      (wr_acc && paddr == `WDX_ADDR_WAKE_FLAG && wake_set_ev == 8'h00)
      |=> wake_flag_r == ($past(wake_flag_r) & $past(pwdata[NPIN-1:0])))
      else $error("wake flag clear wrong");

   dx_set_a: assert property (
      (sleep_exec && ctl_r.direct_xfer_allow && xfer.xfer) |=> dx_flag_r)
      else $error("direct flag not set by transfer");

   dx_clr_a: assert property (
      (wr_acc && paddr == `WDX_ADDR_DX_FLAG && !pwdata[0] && dx_flag_r && !dx_ev)
      |=> !dx_flag_r)
      else $error("direct flag not cleared");

   dx_irq_a: assert property (
      (dx_ev && ctl_r.dx_irq_en && !(wr_acc && paddr == `WDX_ADDR_MODE_CTL))
      |=> direct_xfer_irq_req ##0 dx_flag_r)
      else $error("direct interrupt request wrong");

   mode_med_a: assert property (
      (sleep_exec && mode_r == wdx_pkg::WDX_MODE_HIGH && ctl_r.direct_xfer_allow
       && !ctl_r.standby_select && ctl_r.medium_speed_select && !ctl_r.low_speed_select)
      |=> op_mode == 2'h1 && dx_flag_r)
      else $error("high to medium transfer missed");

   irq_out_a: assert property (
      ($rose(|stat_set) && mask_r == 9'h1ff && !(wr_acc && paddr == `WDX_ADDR_IRQ_MASK))
      |=> irq)
      else $error("interrupt output not raised");

   wake_cov_c: cover property (wake_set_ev != 8'h00 ##1 wr_acc && paddr == `WDX_ADDR_WAKE_FLAG);
   dx_cov_c:   cover property (dx_ev ##[1:20] wr_acc && paddr == `WDX_ADDR_DX_FLAG);
   sub_cov_c:  cover property (dx_ev && xfer.target == wdx_pkg::WDX_MODE_SUB);

endmodule
`default_nettype wire

// [tb/wdx_far_model.sv]
// model of the wakeup pins and the core that issues sleep instructions
`timescale 1ns/1ps
`default_nettype none

module wdx_far_model (
   // clock
   input  wire logic       clk,
   // pins and core
   output logic      [7:0] wake_pin_n,
   output logic            sleep_exec
);
   // pins idle high through their pull-ups
   initial begin
      wake_pin_n = 8'hff;
      sleep_exec = 1'b0;
   end

   // one falling edge on a pin, then back high so the next edge is distinct
   task automatic fall(input int n);
      @(posedge clk) wake_pin_n[n] <= 1'b0;
      @(posedge clk) wake_pin_n[n] <= 1'b1;
   endtask

   // one-cycle sleep instruction pulse from the core
   task automatic sleep();
      @(posedge clk) sleep_exec <= 1'b1;
      @(posedge clk) sleep_exec <= 1'b0;
   endtask
endmodule

`default_nettype wire

// [tb/wakeup_direct_xfer_irq_flags_tb.sv]
// self-checking bench for the wakeup / direct-transfer flag block
`timescale 1ns/1ps
`default_nettype none

module wakeup_direct_xfer_irq_flags_tb;
   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] x;
      logic        e;
   } wdx_row_s;

   logic        clk, reset, psel, penable, pwrite, pready, pslverr, sleep_exec;
   logic        wake_irq_req, direct_xfer_irq_req, irq;
   logic [7:0]  paddr, wake_pin_n;
   logic [31:0] pwdata, prdata, rdat;
   logic [1:0]  op_mode;
   logic        rerr;
   int          fail_count, cmp_count;

   // reset values, read-only and write-zero-to-clear places, unmapped address
   wdx_row_s rows [15] = '{
      '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h0c, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h14, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h18, 32'h0, 32'h0, 1'b0},
      '{1'b0, 8'h1c, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h00, 32'hff, 32'h0, 1'b0},
      '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h04, 32'h1, 32'h0, 1'b0},
      '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h08, 32'hff, 32'h0, 1'b0},
      '{1'b0, 8'h08, 32'h0, 32'hff, 1'b0}, '{1'b1, 8'h10, 32'h1ff, 32'h0, 1'b0},
      '{1'b0, 8'h10, 32'h0, 32'h0, 1'b0}};

   wdx_irq_flags #(.NPIN(8)) DUT (
      .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wake_pin_n(wake_pin_n), .sleep_exec(sleep_exec),
      .wake_irq_req(wake_irq_req), .direct_xfer_irq_req(direct_xfer_irq_req),
      .op_mode(op_mode), .irq(irq));

   wdx_far_model far (.clk(clk), .wake_pin_n(wake_pin_n), .sleep_exec(sleep_exec));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t %s got %h want %h", $time, m, g, e);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      bit done;
      done = 0;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      for (int i = 0; i < 20 && !done; i++) begin
         @(posedge clk);
         if (pready === 1'b1) begin
            done = 1;
            rdat = prdata;
            rerr = pslverr;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (!done) begin
         fail_count++;
         $display("BAD %0t apb wait ran out", $time);
         print_verdict();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk(32'(rerr), 32'h0, "write error");
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(rdat, x, "read data");
   endtask

   task automatic settle();
      @(posedge clk);
      #1;
   endtask

   initial begin
      fail_count = 0;
      cmp_count = 0;
      reset = 1'b1;
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk(32'(rerr), 32'(rows[i].e), "error flag");
         if (!rows[i].w) chk(rdat, rows[i].x, "row read");
      end
      far.fall(0);
      far.fall(7);
      rd(8'h00, 32'h81);
      chk(32'(wake_irq_req), 32'h1, "wake request");
      wr(8'h00, 32'hfe);
      rd(8'h00, 32'h80);
      wr(8'h00, 32'h00);
      rd(8'h00, 32'h00);
      chk(32'(wake_irq_req), 32'h0, "wake request cleared");
      wr(8'h08, 32'h7f);
      far.fall(7);
      rd(8'h00, 32'h00);
      wr(8'h14, 32'h1ff);
      settle();
      chk(32'(irq), 32'h1, "irq with pending status");
      rd(8'h10, 32'h81);
      settle();
      chk(32'(irq), 32'h0, "irq after status read");
      // high to medium with the direct interrupt disabled, then enabled
      wr(8'h0c, 32'h05);
      far.sleep();
      settle();
      chk(32'(op_mode), 32'h1, "mode medium");
      chk(32'(direct_xfer_irq_req), 32'h0, "direct req masked");
      rd(8'h04, 32'h1);
      wr(8'h0c, 32'h25);
      settle();
      chk(32'(direct_xfer_irq_req), 32'h1, "direct req enabled");
      wr(8'h04, 32'h0);
      rd(8'h04, 32'h0);
      wr(8'h0c, 32'h21);
      far.sleep();
      settle();
      chk(32'(op_mode), 32'h0, "mode high");
      chk(32'(direct_xfer_irq_req), 32'h1, "direct req on transfer");
      rd(8'h04, 32'h1);
      wr(8'h04, 32'h0);
      settle();
      chk(32'(direct_xfer_irq_req), 32'h0, "direct req cleared");
      wr(8'h0c, 32'h04);
      far.sleep();
      settle();
      chk(32'(op_mode), 32'h0, "no transfer without allow");
      rd(8'h04, 32'h0);
      wr(8'h0c, 32'h1b);
      far.sleep();
      settle();
      chk(32'(op_mode), 32'h2, "mode subactive");
      rd(8'h04, 32'h1);
      wr(8'h04, 32'h0);
      // no direct transfer leaves subactive
      far.sleep();
      settle();
      chk(32'(op_mode), 32'h2, "subactive stays");
      rd(8'h04, 32'h0);
      // reset in mid-run returns everything to idle
      @(posedge clk) reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      settle();
      chk(32'(op_mode), 32'h0, "mode after reset");
      chk(32'(irq), 32'h0, "irq after reset");
      rd(8'h04, 32'h0);
      rd(8'h00, 32'h0);
      rd(8'h0c, 32'h0);
      rd(8'h10, 32'h0);
      rd(8'h14, 32'h0);
      print_verdict();
   end
endmodule

`default_nettype wire
